// *** rtl/skip_block_slot.sv ***
// one function block slot: holds its output between evaluations
`timescale 1ns/1ps
module skip_block_slot #(
    parameter int WIDTH = 8
) (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic eval,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    // output only moves when the slot is evaluated
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            dout <= '0;
        end else if (eval) begin
            dout <= din;
        end
    end
endmodule : skip_block_slot

// *** rtl/skip_sequencer.sv ***
// scan sequencer with forward conditional skip elements
`timescale 1ns/1ps
`include "skip_seq_map.svh"
// Behaviour
// - enabled element resumes after its paired marker
// - disabled element continues with next entry
// - backward marker: go to end, fault
// - missing marker: go to end, fault
// - up to sixteen target markers
// - pairing strictly by instance number
// - marker is a bare position, no wiring
// - skip re-evaluated every scan while enabled
// - up to sixteen skip elements
// - enable coils driven from inputs or logic
module skip_sequencer #(
    parameter int DEPTH = `SKIP_LIST_DEPTH,
    parameter int NUM = `SKIP_MAX_ELEMENTS,
    parameter int WIDTH = 8
) (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic SCAN_START,
    input wire logic PROG_WE,
    input wire logic [$clog2(DEPTH)-1:0] PROG_ADDR,
    input wire logic [1:0] PROG_KIND,
    input wire logic [$clog2(NUM)-1:0] PROG_NUM,
    input wire logic [NUM-1:0] SKIP_ENABLE_COIL,
    input wire logic [WIDTH-1:0] BLOCK_DIN,
    output logic [NUM-1:0] SKIP_FAULT_CONTACT,
    output logic [DEPTH-1:0] BLOCK_EVAL,
    output logic [$clog2(DEPTH)-1:0] CUR_POS,
    output logic SCAN_BUSY,
    output logic SCAN_DONE
);
    localparam int AW = $clog2(DEPTH);
    localparam int NW = $clog2(NUM);

    // program list: kind and instance number per position
    logic [1:0] kind_r [DEPTH];
    logic [NW-1:0] num_r [DEPTH];
    skip_seq_pkg::seq_state_t state_r;
    logic [AW-1:0] pos_r;
    logic [AW-1:0] origin_r;
    logic [NW-1:0] seek_num_r;
    logic found_r;
    logic [WIDTH-1:0] slot_out [DEPTH];

    function automatic logic is_last(input logic [AW-1:0] p);
        is_last = (p == AW'(DEPTH - 1));
    endfunction : is_last

    // list storage written while idle; markers need no coil or contact
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            for (int i = 0; i < DEPTH; i++) begin
                kind_r[i] <= `SKIP_KIND_END;
                num_r[i] <= '0;
            end
        end else if (PROG_WE && state_r == skip_seq_pkg::ST_IDLE) begin
            kind_r[PROG_ADDR] <= PROG_KIND;
            num_r[PROG_ADDR] <= PROG_NUM;
        end
    end

    // walk the list one entry per cycle; seek marker on taken skip
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            state_r <= skip_seq_pkg::ST_IDLE;
            pos_r <= '0;
            origin_r <= '0;
            seek_num_r <= '0;
            found_r <= 1'b0;
            SCAN_DONE <= 1'b0;
        end else begin
            SCAN_DONE <= 1'b0;
            unique case (state_r)
                skip_seq_pkg::ST_IDLE: begin
                    if (SCAN_START) begin
                        state_r <= skip_seq_pkg::ST_RUN;
                        pos_r <= '0;
                    end
                end
                skip_seq_pkg::ST_RUN: begin
                    if (kind_r[pos_r] == `SKIP_KIND_END || is_last(pos_r)) begin
                        state_r <= skip_seq_pkg::ST_IDLE;
                        SCAN_DONE <= 1'b1;
                    end else if (kind_r[pos_r] == `SKIP_KIND_ELEMENT
                                 && SKIP_ENABLE_COIL[num_r[pos_r]]) begin
                        // search whole list so a backward marker is seen
                        state_r <= skip_seq_pkg::ST_SEEK;
                        origin_r <= pos_r;
                        seek_num_r <= num_r[pos_r];
                        found_r <= 1'b0;
                        pos_r <= '0;
                    end else begin
                        pos_r <= pos_r + 1'b1;
                    end
                end
                skip_seq_pkg::ST_SEEK: begin
                    if (kind_r[pos_r] == `SKIP_KIND_MARKER
                        && num_r[pos_r] == seek_num_r
                        && pos_r > origin_r) begin
                        state_r <= skip_seq_pkg::ST_RUN;
                        pos_r <= pos_r + 1'b1;
                    end else if (kind_r[pos_r] == `SKIP_KIND_END
                                 || is_last(pos_r)) begin
                        // no forward marker: end of list, last rung skipped
                        state_r <= skip_seq_pkg::ST_IDLE;
                        SCAN_DONE <= 1'b1;
                    end else begin
                        pos_r <= pos_r + 1'b1;
                    end
                end
            endcase
        end
    end

    // fault contact per element, refreshed whenever the element is reached
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            SKIP_FAULT_CONTACT <= '0;
        end else if (state_r == skip_seq_pkg::ST_RUN
                     && kind_r[pos_r] == `SKIP_KIND_ELEMENT
                     && !SKIP_ENABLE_COIL[num_r[pos_r]]) begin
            SKIP_FAULT_CONTACT[num_r[pos_r]] <= 1'b0;
        end else if (state_r == skip_seq_pkg::ST_SEEK) begin
            if (kind_r[pos_r] == `SKIP_KIND_MARKER
                && num_r[pos_r] == seek_num_r && pos_r > origin_r) begin
                SKIP_FAULT_CONTACT[seek_num_r] <= 1'b0;
            end else if (kind_r[pos_r] == `SKIP_KIND_END
                         || is_last(pos_r)) begin
                SKIP_FAULT_CONTACT[seek_num_r] <= 1'b1;
            end
        end
    end

    // evaluate strobe only for blocks actually reached
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            BLOCK_EVAL <= '0;
            CUR_POS <= '0;
            SCAN_BUSY <= 1'b0;
        end else begin
            BLOCK_EVAL <= '0;
            if (state_r == skip_seq_pkg::ST_RUN
                && kind_r[pos_r] == `SKIP_KIND_BLOCK) begin
                BLOCK_EVAL[pos_r] <= 1'b1;
            end
            CUR_POS <= pos_r;
            SCAN_BUSY <= (state_r != skip_seq_pkg::ST_IDLE);
        end
    end

    // holding slots: skipped blocks keep their last value
    for (genvar g = 0; g < DEPTH; g++) begin : g_slot
        skip_block_slot #(.WIDTH(WIDTH)) u_slot (
            .CLK(CLK),
            .RESET_N(RESET_N),
            .eval(state_r == skip_seq_pkg::ST_RUN
                  && kind_r[g] == `SKIP_KIND_BLOCK
                  && pos_r == AW'(g)),
            .din(BLOCK_DIN),
            .dout(slot_out[g])
        );
    end
endmodule : skip_sequencer

// *** shared/skip_seq_map.svh ***
// constants for the conditional skip sequencer
`ifndef SKIP_SEQ_MAP_SVH
`define SKIP_SEQ_MAP_SVH
`define SKIP_MAX_ELEMENTS 16
`define SKIP_MAX_MARKERS 16
`define SKIP_LIST_DEPTH 64
`define SKIP_KIND_BLOCK 2'h0
`define SKIP_KIND_ELEMENT 2'h1
`define SKIP_KIND_MARKER 2'h2
`define SKIP_KIND_END 2'h3
`endif

// *** shared/skip_seq_pkg.sv ***
// types shared by the conditional skip sequencer
package skip_seq_pkg;
    typedef enum logic [1:0] {
        KIND_BLOCK = 2'h0,
        KIND_ELEMENT = 2'h1,
        KIND_MARKER = 2'h2,
        KIND_END = 2'h3
    } entry_kind_t;
    typedef enum {
        ST_IDLE,
        ST_RUN,
        ST_SEEK
    } seq_state_t;
endpackage : skip_seq_pkg

// *** verification/coil_logic.sv ***
// circuit-diagram model driving the skip enable coils
`timescale 1ns/1ps
module coil_logic (
    input wire logic CLK,
    input wire logic [15:0] want,
    output logic [15:0] coil
);
    // coil levels follow the diagram state, from terminals or logic
    always_ff @(posedge CLK) coil <= want;
endmodule : coil_logic

// *** verification/skip_seq_assertions.sv ***
// checker for the conditional skip sequencer ports
`timescale 1ns/1ps
module skip_seq_checker #(
    parameter int DEPTH = 64,
    parameter int NUM = 16
) (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic SCAN_START,
    input wire logic SCAN_BUSY,
    input wire logic SCAN_DONE,
    input wire logic [DEPTH-1:0] BLOCK_EVAL,
    input wire logic [NUM-1:0] SKIP_FAULT_CONTACT
);
    // every check samples the scan clock and is quiet during reset
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    a_done_pulse: assert property (SCAN_DONE |=> !SCAN_DONE)
        else $error("scan done held too long");
    a_eval_single: assert property ($onehot0(BLOCK_EVAL))
        else $error("two blocks evaluated at once");
    a_last_skipped: assert property (!BLOCK_EVAL[DEPTH-1])
        else $error("last position evaluated");
    // busy is registered from the walk state, so it lags the start by two
    a_start_busy: assert property (SCAN_START && !SCAN_BUSY |-> ##2 SCAN_BUSY)
        else $error("scan not started");
    // idle long enough that no late pulse can still be in flight
    a_idle_quiet: assert property ((!SCAN_BUSY && !SCAN_START)[*3]
        |=> BLOCK_EVAL == 0) else $error("evaluation while idle");
    a_fault_hold: assert property ((!SCAN_BUSY)[*3]
        |-> $stable(SKIP_FAULT_CONTACT)) else $error("fault moved idle");
    a_scan_bound: assert property ($rose(SCAN_BUSY) |-> ##[1:200] SCAN_DONE)
        else $error("scan never ended");
    a_eval_busy: assert property (BLOCK_EVAL != 0
        |-> SCAN_BUSY || $past(SCAN_BUSY)) else $error("eval out of scan");
endmodule : skip_seq_checker

bind skip_sequencer skip_seq_checker #(.DEPTH(DEPTH), .NUM(NUM)) i_chk (.*);

// *** verification/skip_sequencer_test.sv ***
// self-checking bench for the conditional skip sequencer
`timescale 1ns/1ps
module skip_sequencer_test;
    logic CLK = 0, RESET_N = 0, SCAN_START = 0, PROG_WE = 0;
    logic [2:0] PROG_ADDR = 0, CUR_POS;
    logic [1:0] PROG_KIND = 0;
    logic [3:0] PROG_NUM = 0;
    logic [15:0] want = 0, SKIP_ENABLE_COIL, SKIP_FAULT_CONTACT;
    logic [7:0] BLOCK_DIN = 0, BLOCK_EVAL, seen;
    logic SCAN_BUSY, SCAN_DONE;
    logic [1:0] kinds [7] = '{0, 1, 0, 2, 0, 1, 0};
    logic [3:0] nums [7] = '{0, 5, 0, 5, 0, 9, 0};
    int errors = 0, checks = 0;
    always #5 CLK = ~CLK;
    skip_sequencer #(.DEPTH(8)) i_skip_sequencer (.*);
    coil_logic i_coil_logic (.CLK(CLK), .want(want),
        .coil(SKIP_ENABLE_COIL));
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    // one list write; the cycle gap keeps each strobe a clean pulse
    task automatic wr(input logic [2:0] a, input logic [1:0] k,
        input logic [3:0] n);
        @(posedge CLK);
        PROG_WE <= 1;
        PROG_ADDR <= a;
        PROG_KIND <= k;
        PROG_NUM <= n;
        @(posedge CLK);
        PROG_WE <= 0;
    endtask : wr
    // one scan; only even positions are judged, odd ones are never blocks
    task automatic scan(input logic [15:0] c, input logic [7:0] exp,
        input logic [15:0] f);
        int n;
        @(posedge CLK);
        want <= c;
        SCAN_START <= 1;
        @(posedge CLK);
        SCAN_START <= 0;
        seen = 0;
        for (n = 0; n < 300 && SCAN_DONE !== 1; n++) begin
            @(negedge CLK);
            seen |= BLOCK_EVAL;
        end
        @(negedge CLK);
        seen |= BLOCK_EVAL;
        cmp({8'h00, seen & 8'h55}, {8'h00, exp});
        cmp(SKIP_FAULT_CONTACT, f);
        // every scan in this list ends on the end entry at position 7
        cmp({13'h0000, CUR_POS}, 16'h0007);
        cmp({15'h0000, SCAN_BUSY}, 16'h0000);
    endtask : scan
    task automatic summarize;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : summarize
    initial begin
        repeat (10) @(posedge CLK);
        RESET_N <= 1;
        for (int i = 0; i < 7; i++) wr(3'(i), kinds[i], nums[i]);
        scan(16'h0000, 8'h55, 16'h0000);
        scan(16'h0020, 8'h51, 16'h0000);
        scan(16'h0020, 8'h51, 16'h0000);
        scan(16'h0220, 8'h11, 16'h0200);
        wr(3'h2, 2'h2, 4'h9);
        // clear the fault first so the backward case must set it again
        scan(16'h0000, 8'h51, 16'h0000);
        scan(16'h0220, 8'h11, 16'h0200);
        scan(16'h0020, 8'h51, 16'h0000);
        summarize();
    end
    // hang guard at 5000 cycles, far beyond the under two hundred cycles the whole test needs
    initial begin
        #50000;
        errors++;
        summarize();
    end
endmodule : skip_sequencer_test
